//--- logic/mcu_port_pkg.sv
// Constants shared by the port and external bus logic
package mcu_port_pkg;
    localparam int          OSC_PER_MACHINE = 12;
    localparam int          RST_HOLD_CYCLES = 2 * OSC_PER_MACHINE;
    localparam logic [3:0]  PHASE_LAST      = 4'hB;
    localparam logic [3:0]  HALF_LEN        = 4'h6;
    localparam logic [3:0]  SUB_ALE_END     = 4'h1;
    localparam logic [3:0]  SUB_ADDR_END    = 4'h2;
    localparam logic [3:0]  SUB_STROBE_BEG  = 4'h3;
    localparam logic [3:0]  SUB_SAMPLE      = 4'h5;
    localparam logic [3:0]  DATA_STROBE_BEG = 4'h4;
    localparam logic [3:0]  DATA_STROBE_END = 4'hA;
    localparam logic [3:0]  DATA_DRIVE_BEG  = 4'h3;
    localparam logic [15:0] INT_ROM_LIMIT   = 16'h3FFF;
    localparam logic [7:0]  SFR_PORT0       = 8'h80;
    localparam logic [7:0]  SFR_PORT1       = 8'h90;
    localparam logic [7:0]  SFR_UPPER_PORT  = 8'hA0;
    localparam logic [7:0]  SFR_PORT3       = 8'hB0;
    localparam logic [7:0]  SFR_STROBE_CTL  = 8'hAF;
    localparam int          STROBE_OFF_BIT  = 0;
    localparam logic [7:0]  PORT_RESET      = 8'hFF;
    localparam int          P3_TX_BIT       = 1;
    localparam int          P3_WR_BIT       = 6;
    localparam int          P3_RD_BIT       = 7;

    typedef enum logic [3:0] {
        CYC_INT   = 4'b0001,
        CYC_FETCH = 4'b0010,
        CYC_READ  = 4'b0100,
        CYC_WRITE = 4'b1000
    } cycle_kind_t;
endpackage

//--- logic/port_driver.sv
// Pin driver for one 8-bit port, open-drain or quasi-bidirectional
`timescale 1ns/1ps
`default_nettype none
module port_driver #(
    parameter bit OPEN_DRAIN = 1'b0
) (
    input  wire logic [7:0] latchVal,
    input  wire logic       busEn,
    input  wire logic [7:0] busVal,
    input  wire logic       forceHigh,
    output logic      [7:0] padOut,
    output logic      [7:0] padOe,
    output logic      [7:0] padPull
);
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_bit
            always_comb begin
                if (forceHigh && !OPEN_DRAIN) begin
                    padOut[i]  = 1'b1;
                    padOe[i]   = 1'b0;
                    padPull[i] = 1'b1;
                end else if (busEn) begin
                    padOut[i]  = busVal[i];
                    padOe[i]   = 1'b1;
                    padPull[i] = 1'b0;
                end else begin
                    padOut[i]  = 1'b0;
                    padOe[i]   = ~latchVal[i];
                    padPull[i] = latchVal[i] & !OPEN_DRAIN;
                end
            end
        end
    endgenerate
endmodule // port_driver
`default_nettype wire

//--- logic/mcu_port_bus.sv
// Ports 0-3, multiplexed external memory bus, strobes and reset pin
`timescale 1ns/1ps
`default_nettype none
module mcu_port_bus
    import mcu_port_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        rstPin,
    input  wire logic        externalAccessSelect,
    input  wire logic        verifyMode,
    input  wire logic [7:0]  p0In,
    output logic      [7:0]  p0Out,
    output logic      [7:0]  p0Oe,
    output logic      [7:0]  p0Pull,
    input  wire logic [7:0]  p1In,
    output logic      [7:0]  p1Out,
    output logic      [7:0]  p1Oe,
    output logic      [7:0]  p1Pull,
    input  wire logic [7:0]  p2In,
    output logic      [7:0]  p2Out,
    output logic      [7:0]  p2Oe,
    output logic      [7:0]  p2Pull,
    input  wire logic [7:0]  p3In,
    output logic      [7:0]  p3Out,
    output logic      [7:0]  p3Oe,
    output logic      [7:0]  p3Pull,
    output logic             aleOut,
    output logic             programReadStrobeN,
    output logic             deviceReset,
    input  wire logic [15:0] fetchAddr,
    input  wire logic        dataReq,
    input  wire logic        dataWide,
    input  wire logic        dataWrite,
    input  wire logic [15:0] dataAddr,
    input  wire logic [7:0]  dataWdata,
    output logic             cycleDone,
    output logic             extFetch,
    output logic      [7:0]  codeByte,
    output logic             codeValid,
    output logic      [7:0]  dataRdata,
    output logic             dataValid,
    output logic      [15:0] romAddr,
    input  wire logic [7:0]  romData,
    input  wire logic        sfrWrite,
    input  wire logic        sfrRead,
    input  wire logic [7:0]  sfrAddr,
    input  wire logic [7:0]  sfrWdata,
    output logic      [7:0]  sfrRdata,
    input  wire logic        serialTx,
    output logic             serialRx,
    output logic             externalInterruptZero,
    output logic             externalInterruptOne,
    output logic             timerZeroInput,
    output logic             timerOneInput
);
    // Reset release synchroniser
    logic       rstMeta, rstN;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            {rstMeta, rstN} <= 2'b00;
        end else begin
            {rstMeta, rstN} <= {1'b1, rstMeta};
        end
    end
    // Reset pin qualifier
    logic [4:0] rstCount, next_rstCount;
    logic       next_deviceReset;
    always_comb begin
        next_rstCount    = rstCount;
        next_deviceReset = deviceReset;
        if (!rstPin) begin
            next_rstCount    = '0;
            next_deviceReset = 1'b0;
        end else if (rstCount == 5'(RST_HOLD_CYCLES - 1)) begin
            next_deviceReset = 1'b1;
        end else begin
            next_rstCount = rstCount + 5'h01;
        end
    end
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            rstCount    <= '0;
            deviceReset <= 1'b1;
        end else begin
            rstCount    <= next_rstCount;
            deviceReset <= next_deviceReset;
        end
    end

    // Machine cycle sequencer
    cycle_kind_t kind, next_kind;
    logic [3:0]  phase, next_phase;
    logic [15:0] curAddr, next_curAddr;
    logic        curWide, next_curWide, wantExt;
    logic [7:0]  curWdata, next_curWdata;
    assign wantExt   = !externalAccessSelect || (fetchAddr > INT_ROM_LIMIT);
    assign cycleDone = (phase == PHASE_LAST) && !deviceReset;
    always_comb begin
        next_phase    = phase + 4'h1;
        next_kind     = kind;
        next_curAddr  = curAddr;
        next_curWide  = curWide;
        next_curWdata = curWdata;
        if (deviceReset) begin
            next_phase = '0;
            next_kind  = CYC_INT;
        end else if (phase == PHASE_LAST) begin
            next_phase    = '0;
            next_curWide  = dataWide;
            next_curWdata = dataWdata;
            if (dataReq) begin
                next_kind    = dataWrite ? CYC_WRITE : CYC_READ;
                next_curAddr = dataAddr;
            end else begin
                next_kind    = wantExt ? CYC_FETCH : CYC_INT;
                next_curAddr = fetchAddr;
            end
        end
    end
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            phase    <= '0;
            kind     <= CYC_INT;
            curAddr  <= '0;
            curWide  <= 1'b0;
            curWdata <= '0;
        end else begin
            phase    <= next_phase;
            kind     <= next_kind;
            curAddr  <= next_curAddr;
            curWide  <= next_curWide;
            curWdata <= next_curWdata;
        end
    end
    // Special function registers
    logic [7:0] p0Latch, p1Latch, upperPortLatch, p3Latch;
    logic [7:0] next_p0Latch, next_p1Latch, next_upperPortLatch, next_p3Latch, next_sfrRdata;
    logic       strobeOff, next_strobeOff;
    always_comb begin
        next_p0Latch        = p0Latch;
        next_p1Latch        = p1Latch;
        next_upperPortLatch = upperPortLatch;
        next_p3Latch        = p3Latch;
        next_strobeOff      = strobeOff;
        next_sfrRdata       = sfrRdata;
        if (deviceReset) begin
            next_p0Latch        = PORT_RESET;
            next_p1Latch        = PORT_RESET;
            next_upperPortLatch = PORT_RESET;
            next_p3Latch        = PORT_RESET;
            next_strobeOff      = 1'b0;
        end else if (sfrWrite) begin
            unique case (sfrAddr)
                SFR_PORT0:      next_p0Latch        = sfrWdata;
                SFR_PORT1:      next_p1Latch        = sfrWdata;
                SFR_UPPER_PORT: next_upperPortLatch = sfrWdata;
                SFR_PORT3:      next_p3Latch        = sfrWdata;
                SFR_STROBE_CTL: next_strobeOff      = sfrWdata[STROBE_OFF_BIT];
                default:        next_strobeOff      = strobeOff;
            endcase
        end
        if (sfrRead) begin
            unique case (sfrAddr)
                SFR_PORT0:      next_sfrRdata = p0In;
                SFR_PORT1:      next_sfrRdata = p1In;
                SFR_UPPER_PORT: next_sfrRdata = p2In;
                SFR_PORT3:      next_sfrRdata = p3In;
                SFR_STROBE_CTL: next_sfrRdata = {7'h00, strobeOff};
                default:        next_sfrRdata = 8'h00;
            endcase
        end
    end
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            {p0Latch, p1Latch, upperPortLatch, p3Latch} <= {4{PORT_RESET}};
            strobeOff      <= 1'b0;
            sfrRdata       <= 8'h00;
        end else begin
            {p0Latch, p1Latch, upperPortLatch, p3Latch} <=
                {next_p0Latch, next_p1Latch, next_upperPortLatch, next_p3Latch};
            strobeOff      <= next_strobeOff;
            sfrRdata       <= next_sfrRdata;
        end
    end
    // Bus drive, computed for the phase about to start so pins line up with it
    logic       secondHalf, isExt, isData, wrN, rdN, p0En, p2En;
    logic [3:0] sub;
    logic [7:0] lowAddr, p0Val, p2Val, next_p0Val, next_p2Val;
    logic       next_ale, next_readN, next_wrN, next_rdN, next_p0En, next_p2En;
    always_comb begin
        secondHalf = next_phase >= HALF_LEN;
        sub        = secondHalf ? next_phase - HALF_LEN : next_phase;
        isData     = (next_kind == CYC_READ) || (next_kind == CYC_WRITE);
        isExt      = isData || (next_kind == CYC_FETCH);
        lowAddr    = next_curAddr[7:0] + {7'h00, secondHalf && !isData};
        // Second half of a data cycle has no latch pulse
        next_ale   = (sub <= SUB_ALE_END) && !(isData && secondHalf);
        if (strobeOff && !isExt) begin
            next_ale = 1'b0;
        end
        next_readN = !((next_kind == CYC_FETCH) && (sub >= SUB_STROBE_BEG));
        next_wrN   = !((next_kind == CYC_WRITE) && (next_phase >= DATA_STROBE_BEG)
                     && (next_phase <= DATA_STROBE_END));
        next_rdN   = !((next_kind == CYC_READ) && (next_phase >= DATA_STROBE_BEG)
                     && (next_phase <= DATA_STROBE_END));
        next_p0En  = 1'b0;
        next_p0Val = lowAddr;
        if (isExt && !secondHalf && (sub <= SUB_ADDR_END)) begin
            next_p0En = 1'b1;
        end else if ((next_kind == CYC_FETCH) && secondHalf && (sub <= SUB_ADDR_END)) begin
            next_p0En = 1'b1;
        end else if ((next_kind == CYC_WRITE) && (next_phase >= DATA_DRIVE_BEG)) begin
            next_p0En  = 1'b1;
            next_p0Val = next_curWdata;
        end
        next_p2En  = (next_kind == CYC_FETCH) || (isData && next_curWide);
        next_p2Val = next_curAddr[15:8];
        if (isData && !next_curWide) begin
            next_p2En  = 1'b1;
            next_p2Val = next_upperPortLatch;
        end
        if (deviceReset || verifyMode) begin
            next_p0En  = 1'b0;
            next_p2En  = 1'b0;
            next_readN = 1'b1;
            next_wrN   = 1'b1;
            next_rdN   = 1'b1;
        end
    end
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            {aleOut, p0En, p2En}           <= 3'b000;
            {programReadStrobeN, wrN, rdN} <= 3'b111;
            {p0Val, p2Val}                 <= '0;
        end else begin
            {aleOut, p0En, p2En}           <= {next_ale, next_p0En, next_p2En};
            {programReadStrobeN, wrN, rdN} <= {next_readN, next_wrN, next_rdN};
            {p0Val, p2Val}                 <= {next_p0Val, next_p2Val};
        end
    end
    // Code and data capture; external data is sampled on the last strobe cycle
    logic        sampleNow, next_codeValid, next_dataValid;
    logic [7:0]  next_codeByte, next_dataRdata, p3Sample;
    logic [15:0] next_romAddr;
    always_comb begin
        sampleNow      = ((phase >= HALF_LEN) ? phase - HALF_LEN : phase) == SUB_SAMPLE;
        next_codeByte  = codeByte;
        next_codeValid = 1'b0;
        next_dataRdata = dataRdata;
        next_dataValid = 1'b0;
        next_romAddr   = curAddr + {15'h0000, phase >= HALF_LEN};
        if (verifyMode) begin
            next_romAddr  = {p2In, p1In};
            next_codeByte = romData;
        end else if (!deviceReset && sampleNow && (kind == CYC_FETCH)) begin
            next_codeByte  = p0In;
            next_codeValid = 1'b1;
        end else if (!deviceReset && sampleNow && (kind == CYC_INT)) begin
            next_codeByte  = romData;
            next_codeValid = 1'b1;
        end
        if (!deviceReset && (kind == CYC_READ) && (phase == DATA_STROBE_END)) begin
            next_dataRdata = p0In;
            next_dataValid = 1'b1;
        end
    end
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            codeByte  <= '0;
            codeValid <= 1'b0;
            dataRdata <= '0;
            dataValid <= 1'b0;
            romAddr   <= '0;
            extFetch  <= 1'b0;
            p3Sample  <= PORT_RESET;
        end else begin
            codeByte  <= next_codeByte;
            codeValid <= next_codeValid;
            dataRdata <= next_dataRdata;
            dataValid <= next_dataValid;
            romAddr   <= next_romAddr;
            extFetch  <= next_kind == CYC_FETCH;
            p3Sample  <= p3In;
        end
    end
    // Port 3 alternate inputs, pins are synchronous to the core clock
    assign serialRx = p3Sample[0];
    assign {timerOneInput, timerZeroInput, externalInterruptOne, externalInterruptZero}
        = p3Sample[5:2];
    // Alternate outputs only pull low; latch must hold one to let them through
    logic [7:0] p3Eff, p0Eff;
    logic       forceHigh;
    always_comb begin
        p3Eff             = p3Latch;
        p3Eff[P3_TX_BIT]  = p3Latch[P3_TX_BIT] & serialTx;
        p3Eff[P3_WR_BIT]  = p3Latch[P3_WR_BIT] & wrN;
        p3Eff[P3_RD_BIT]  = p3Latch[P3_RD_BIT] & rdN;
        // Verify returns code open-drain, so the board needs pullups
        p0Eff             = verifyMode ? codeByte : p0Latch;
    end
    // Raw pin, not the qualified reset, so ports 1-3 go high before any clock
    assign forceHigh = rstPin || !rstN;
    port_driver #(.OPEN_DRAIN(1'b1)) u_port0 (.latchVal(p0Eff), .busEn(p0En), .busVal(p0Val),
        .forceHigh(1'b0), .padOut(p0Out), .padOe(p0Oe), .padPull(p0Pull));
    port_driver #(.OPEN_DRAIN(1'b0)) u_port1 (.latchVal(p1Latch), .busEn(1'b0), .busVal(8'h00),
        .forceHigh(forceHigh), .padOut(p1Out), .padOe(p1Oe), .padPull(p1Pull));
    port_driver #(.OPEN_DRAIN(1'b0)) u_port2 (.latchVal(upperPortLatch), .busEn(p2En),
        .busVal(p2Val), .forceHigh(forceHigh), .padOut(p2Out), .padOe(p2Oe), .padPull(p2Pull));
    port_driver #(.OPEN_DRAIN(1'b0)) u_port3 (.latchVal(p3Eff), .busEn(1'b0), .busVal(8'h00),
        .forceHigh(forceHigh), .padOut(p3Out), .padOe(p3Oe), .padPull(p3Pull));
endmodule // mcu_port_bus
`default_nettype wire

//--- dv/mcu_port_bus_chk.sv
// Pin-level assertions for the port and external bus block
`timescale 1ns/1ps
`default_nettype none
module mcu_port_bus_chk
    import mcu_port_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       nrst,
    input wire logic       rstPin,
    input wire logic       externalAccessSelect,
    input wire logic       dataReq,
    input wire logic       cycleDone,
    input wire logic       extFetch,
    input wire logic       deviceReset,
    input wire logic       aleOut,
    input wire logic       programReadStrobeN,
    input wire logic [7:0] p0Pull,
    input wire logic [7:0] p1Oe,
    input wire logic [7:0] p1Pull,
    input wire logic [7:0] p2Oe,
    input wire logic [7:0] p2Pull,
    input wire logic [7:0] p3Oe,
    input wire logic [7:0] p3Out,
    input wire logic [7:0] p3Pull
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic [4:0] hiCnt;
    logic [4:0] next_hiCnt;
    // Saturates so a long hold never wraps under the threshold
    always_comb next_hiCnt = !rstPin ? 5'h00 : (hiCnt == 5'h1F ? hiCnt : hiCnt + 5'h01);
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst)
            hiCnt <= 5'h00;
        else
            hiCnt <= next_hiCnt;
    end
    sequence ale_pulse;
        aleOut[*2] ##1 !aleOut[*4];
    endsequence
    sequence strobe_low;
        !programReadStrobeN[*3] ##1 programReadStrobeN;
    endsequence
    sequence read_low;
        (p3Oe[P3_RD_BIT] && !p3Out[P3_RD_BIT] && !aleOut && programReadStrobeN)[*7];
    endsequence
    a_port0_float: assert property (p0Pull == 8'h00)
        else $error("port 0 shows a pullup");
    a_weak_pull: assert property (((p1Oe | p1Pull) & (p2Oe | p2Pull) & (p3Oe | p3Pull)) == 8'hFF)
        else $error("port pin neither driven nor pulled");
    a_ports_forced: assert property (rstPin |-> (p1Oe | p2Oe | p3Oe) == 8'h00 && (p1Pull & p2Pull & p3Pull) == PORT_RESET)
        else $error("ports not forced high by reset pin");
    a_ale_shape: assert property (disable iff (!nrst || deviceReset) $rose(aleOut) |-> ale_pulse)
        else $error("latch strobe width or spacing wrong");
    a_strobe_shape: assert property (disable iff (!nrst || deviceReset) $fell(programReadStrobeN) |-> strobe_low)
        else $error("program read strobe width wrong");
    a_strobe_source: assert property ($fell(programReadStrobeN) |-> extFetch)
        else $error("program read strobe outside external fetch");
    a_read_strobe: assert property (disable iff (!nrst || deviceReset) $rose(p3Oe[P3_RD_BIT]) |-> read_low ##1 !p3Oe[P3_RD_BIT])
        else $error("data read strobe shape wrong");
    a_ext_select: assert property (disable iff (!nrst || deviceReset) cycleDone && !dataReq && !externalAccessSelect |-> ##2 extFetch[*8])
        else $error("select low did not give external fetch");
    a_reset_qualify: assert property (int'(hiCnt) == RST_HOLD_CYCLES + 2 |-> deviceReset)
        else $error("long reset pin hold not taken");
endmodule // mcu_port_bus_chk
bind mcu_port_bus mcu_port_bus_chk u_mcu_port_bus_chk (.core_clk, .nrst, .rstPin,
    .externalAccessSelect, .dataReq, .cycleDone, .extFetch, .deviceReset, .aleOut,
    .programReadStrobeN, .p0Pull, .p1Oe, .p1Pull, .p2Oe, .p2Pull, .p3Oe, .p3Out, .p3Pull);
`default_nettype wire

//--- dv/ext_memory_model.sv
// External code and data memory with its low address latch
`timescale 1ns/1ps
`default_nettype none
module ext_memory_model
    import mcu_port_pkg::*;
(
    input  wire logic        aleOut,
    input  wire logic        programReadStrobeN,
    input  wire logic [7:0]  p0Pin,
    input  wire logic [7:0]  p2Pin,
    input  wire logic [7:0]  p3Pin,
    output logic             memOe,
    output logic      [7:0]  memOut,
    output logic      [7:0]  lastWrite,
    output logic      [15:0] lastAddr
);
    logic [7:0]  lowAddr = 8'h00;
    logic [15:0] addr;
    assign addr = {p2Pin, lowAddr};
    always @(negedge aleOut) lowAddr = p0Pin;
    // Contents are a fixed function of address, no storage needed
    assign memOe = !programReadStrobeN || !p3Pin[P3_RD_BIT];
    assign memOut = addr[7:0] + addr[15:8] + 8'h11;
    always @(posedge p3Pin[P3_WR_BIT]) begin
        lastWrite = p0Pin;
        lastAddr = addr;
    end
endmodule // ext_memory_model
`default_nettype wire

//--- dv/tb.sv
// Testbench for the port and external bus block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import mcu_port_pkg::*;
    logic core_clk, nrst, rstPin, externalAccessSelect, verifyMode, serialTx, memOe;
    logic [7:0] p0In, p0Out, p0Oe, p0Pull, p1In, p1Out, p1Oe, p1Pull, memOut, lastWrite;
    logic [7:0] p2In, p2Out, p2Oe, p2Pull, p3In, p3Out, p3Oe, p3Pull, rd;
    logic aleOut, programReadStrobeN, deviceReset, dataReq, dataWide, dataWrite;
    logic cycleDone, extFetch, codeValid, dataValid, sfrWrite, sfrRead, aleD, psD;
    logic serialRx, externalInterruptZero, externalInterruptOne, timerZeroInput, timerOneInput;
    logic [15:0] fetchAddr, dataAddr, romAddr, lastAddr;
    logic [7:0] dataWdata, codeByte, dataRdata, romData, sfrAddr, sfrWdata, sfrRdata;
    logic [7:0] p0Prev = 8'h00;
    logic [7:0] codeQ[$];
    logic [7:0] dataQ[$];
    int aleCnt, psCnt, mismatches, totalChecks;
    bit counting;
    mcu_port_bus u_mcu_port_bus (.core_clk, .nrst, .rstPin, .externalAccessSelect, .verifyMode,
        .p0In, .p0Out, .p0Oe, .p0Pull, .p1In, .p1Out, .p1Oe, .p1Pull, .p2In, .p2Out, .p2Oe,
        .p2Pull, .p3In, .p3Out, .p3Oe, .p3Pull, .aleOut, .programReadStrobeN, .deviceReset,
        .fetchAddr, .dataReq, .dataWide, .dataWrite, .dataAddr, .dataWdata, .cycleDone,
        .extFetch, .codeByte, .codeValid, .dataRdata, .dataValid, .romAddr, .romData,
        .sfrWrite, .sfrRead, .sfrAddr, .sfrWdata, .sfrRdata, .serialTx, .serialRx,
        .externalInterruptZero, .externalInterruptOne, .timerZeroInput, .timerOneInput);
    ext_memory_model u_ext_memory_model (.aleOut, .programReadStrobeN, .p0Pin(p0In),
        .p2Pin(p2In), .p3Pin(p3In), .memOe, .memOut, .lastWrite, .lastAddr);
    // Undriven port 0 has no pullup: show a changing level, not a stale one
    assign p0In = (p0Oe & p0Out) | (~p0Oe & (memOe ? memOut : ~p0Prev));
    assign p1In = (p1Oe & p1Out) | ~p1Oe;
    assign p2In = (p2Oe & p2Out) | ~p2Oe;
    assign p3In = (p3Oe & p3Out) | ~p3Oe;
    assign romData = romAddr[7:0] ^ 8'hC3;
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        p0Prev <= p0In;
        aleD <= aleOut;
        psD <= programReadStrobeN;
        if (counting) begin
            aleCnt += (aleOut && !aleD) ? 1 : 0;
            psCnt += (!programReadStrobeN && psD) ? 1 : 0;
            if (codeValid === 1'b1) codeQ.push_back(codeByte);
            if (dataValid === 1'b1) dataQ.push_back(dataRdata);
        end
    end
    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] + a[15:8] + 8'h11;
    endfunction
    task automatic wrapUp();
        $display("checks %0d mismatches %0d", totalChecks, mismatches);
        if (mismatches == 0 && totalChecks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        totalChecks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic sfrWr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        sfrAddr <= a;
        sfrWdata <= d;
        sfrWrite <= 1'b1;
        @(posedge core_clk);
        sfrWrite <= 1'b0;
    endtask
    task automatic sfrRd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        sfrAddr <= a;
        sfrRead <= 1'b1;
        @(posedge core_clk);
        sfrRead <= 1'b0;
        @(posedge core_clk);
        d = sfrRdata;
    endtask
    task automatic waitTake();
        int n;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (cycleDone !== 1'b1 && n < 40);
        if (n >= 40) begin
            mismatches++;
            wrapUp();
        end
        @(posedge core_clk);
    endtask
    // Two takes first, so the counted window holds one kind of cycle only
    task automatic runCase(input logic sel, input logic [15:0] fa, input logic [2:0] kind,
                           input logic [15:0] da);
        @(posedge core_clk);
        externalAccessSelect <= sel;
        fetchAddr <= fa;
        {dataReq, dataWide, dataWrite} <= kind;
        dataAddr <= da;
        dataWdata <= 8'hA5;
        waitTake();
        waitTake();
        @(negedge core_clk);
        {aleCnt, psCnt} = '0;
        codeQ.delete();
        dataQ.delete();
        counting = 1'b1;
        repeat (12) @(posedge core_clk);
        @(negedge core_clk);
        counting = 1'b0;
    endtask
    task automatic checkBus(input int ale, input int ps, input logic [7:0] e0, e1, input bit isData);
        cmp(16'(aleCnt), 16'(ale));
        cmp(16'(psCnt), 16'(ps));
        if (isData) begin
            cmp(16'(dataQ.size()), 16'h0001);
            if (dataQ.size() > 0) cmp({8'h00, dataQ[0]}, {8'h00, e0});
        end else begin
            cmp(16'(codeQ.size()), 16'h0002);
            if (codeQ.size() == 2) cmp({codeQ[0] ^ codeQ[1], codeQ[0] & codeQ[1]}, {e0 ^ e1, e0 & e1});
        end
    endtask
    initial begin
        {nrst, rstPin, verifyMode, dataReq, dataWide, dataWrite, sfrWrite, sfrRead} = 8'h00;
        {externalAccessSelect, serialTx, counting} = 3'b110;
        {fetchAddr, dataAddr, dataWdata, sfrAddr, sfrWdata} = {16'h0100, 16'h0000, 24'h000000};
        repeat (2) @(posedge core_clk);
        cmp({p1Oe, p3Pull}, {8'h00, PORT_RESET});
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        waitTake();
        sfrRd(SFR_STROBE_CTL, rd);
        cmp({15'h0000, rd[STROBE_OFF_BIT]}, 16'h0000);
        sfrWr(SFR_PORT1, 8'h5A);
        sfrWr(SFR_PORT0, 8'h0F);
        @(negedge core_clk);
        cmp({p1Oe, p1Pull}, 16'hA55A);
        cmp({p0Oe, p0Pull}, 16'hF000);
        sfrWr(SFR_PORT0, 8'hFF);
        sfrWr(SFR_UPPER_PORT, 8'h3C);
        sfrWr(8'h81, 8'h33);
        sfrRd(8'h81, rd);
        cmp({8'h00, rd}, 16'h0000);
        $display("test registers done");
        runCase(1'b1, 16'h0100, 3'b000, 16'h0000);
        checkBus(2, 0, 8'hC3, 8'hC2, 1'b0);
        runCase(1'b1, 16'h4000, 3'b000, 16'h0000);
        checkBus(2, 2, pat(16'h4000), pat(16'h4001), 1'b0);
        runCase(1'b0, 16'h0100, 3'b000, 16'h0000);
        checkBus(2, 2, pat(16'h0100), pat(16'h0101), 1'b0);
        runCase(1'b1, 16'h4000, 3'b110, 16'h1234);
        checkBus(1, 0, pat(16'h1234), 8'h00, 1'b1);
        runCase(1'b1, 16'h4000, 3'b100, 16'h1277);
        checkBus(1, 0, pat(16'h3C77), 8'h00, 1'b1);
        runCase(1'b1, 16'h4000, 3'b111, 16'h2345);
        cmp({8'h00, lastWrite}, 16'h00A5);
        cmp(lastAddr, 16'h2345);
        $display("test bus done");
        sfrWr(SFR_STROBE_CTL, 8'h01);
        runCase(1'b1, 16'h4000, 3'b000, 16'h0000);
        checkBus(2, 2, pat(16'h4000), pat(16'h4001), 1'b0);
        runCase(1'b1, 16'h0100, 3'b000, 16'h0000);
        checkBus(0, 0, 8'hC3, 8'hC2, 1'b0);
        verifyMode <= 1'b1;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        cmp({8'h00, ~p0Oe}, 16'h0099);
        verifyMode <= 1'b0;
        $display("test strobe disable done");
        @(posedge core_clk);
        rstPin <= 1'b1;
        repeat (22) @(posedge core_clk);
        cmp({p1Oe, p1Pull}, {8'h00, PORT_RESET});
        rstPin <= 1'b0;
        repeat (3) @(posedge core_clk);
        cmp({15'h0000, deviceReset}, 16'h0000);
        sfrRd(SFR_STROBE_CTL, rd);
        cmp({15'h0000, rd[STROBE_OFF_BIT]}, 16'h0001);
        @(posedge core_clk);
        rstPin <= 1'b1;
        repeat (30) @(posedge core_clk);
        cmp({15'h0000, deviceReset}, 16'h0001);
        rstPin <= 1'b0;
        waitTake();
        sfrRd(SFR_STROBE_CTL, rd);
        cmp({15'h0000, rd[STROBE_OFF_BIT]}, 16'h0000);
        cmp({p1Oe, p1Pull}, {8'h00, PORT_RESET});
        $display("test reset pin done");
        wrapUp();
    end
endmodule // tb
`default_nettype wire
